// *** design/urc_rx_status_top.sv ***
/*
 * Receive status byte encoder with its event latch and APB registers.
 * Builds the status byte from line state, bus-voltage comparators,
 * receive events, the ID level and the latched non-USB events, and
 * sends it on the 8-bit link data bus when the bus is ours to use.
 * Assumes all sense inputs are synchronous to clk and that the receive
 * datapath reports its own bus direction and next-data signals.
 */
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// [R1] rx events in bits 5:4: 00 idle, 01 active, 11 error, 10 disconnect wins
// [R2] bit 6 carries the ID pin level, low A-device, high B-device
// [R3] bit 7 set while any unmasked event sits in the event latch
// [R4] link reads the event latch to learn which source raised bit 7
// [R5] ID measurement done and ID pin change both set latch events
// [R6] line state bit 0 follows DP, bit 1 follows DM
// [R7] both low reads as single-ended zero, both high single-ended one
// [R8] bus-voltage code in bits 3:2 from the three comparators
// [R9] line state change with direction low sends a status byte at once
// [R10] any bus-voltage or ID comparator change sends a new status byte
// [R11] while receiving, status bytes go out when direction high, next low
module urc_rx_status_top (
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // line and comparator senses
    input wire urc_pkg::urc_sense_t sense,
    // receive datapath events
    input wire logic rxActive,
    input wire logic rxError,
    input wire logic hostDisconnect,
    input wire logic idResistanceMeasureDone,
    // receive datapath bus control
    input wire logic usbRxDir,
    input wire logic usbRxNxt,
    // link data bus
    output logic ulpiDir,
    output logic [7:0] ulpiData,
    output logic ulpiDataOeN,
    output logic statusSent
);

    // ------------------------------------------------------------
    // status byte fields
    // ------------------------------------------------------------
    urc_pkg::urc_status_t receiveStatusByte;
    logic [1:0] lineState;
    logic [1:0] rxEvent;
    logic [1:0] vbusCode;
    logic [urc_pkg::EVT_WIDTH-1:0] eventLatch;
    logic [urc_pkg::EVT_WIDTH-1:0] eventMask;
    logic [urc_pkg::EVT_WIDTH-1:0] eventSet;
    logic altEvent;

    // dp in bit 0, dm in bit 1; 00 is se0 and 11 is se1 by construction
    assign lineState = {sense.fsDm, sense.fsDp}; // [R6] [R7]

    // disconnect overrides the other two event inputs
    always_comb begin
        if (hostDisconnect) begin
            rxEvent = urc_pkg::RXEV_HOST_DISCONNECT; // [R1]
        end else if (rxActive && rxError) begin
            rxEvent = urc_pkg::RXEV_ACTIVE_ERROR; // [R1]
        end else if (rxActive) begin
            rxEvent = urc_pkg::RXEV_ACTIVE; // [R1]
        end else begin
            rxEvent = urc_pkg::RXEV_NONE; // [R1]
        end
    end

    // highest comparator that reports wins; lower ones are don't care
    always_comb begin
        if (sense.busVoltageAboveValid) begin
            vbusCode = urc_pkg::VBUS_ABOVE_VALID; // [R8]
        end else if (sense.sessionValid) begin
            vbusCode = urc_pkg::VBUS_SESSION_TO_VALID; // [R8]
        end else if (!sense.sessionEndIndicator) begin
            vbusCode = urc_pkg::VBUS_END_TO_SESSION; // [R8]
        end else begin
            vbusCode = urc_pkg::VBUS_BELOW_END; // [R8]
        end
    end

    assign altEvent = |(eventLatch & eventMask); // [R3]

    // assemble the byte
    always_comb begin
        receiveStatusByte.altEvent = altEvent; // [R3]
        receiveStatusByte.idLevel = sense.idPin; // [R2]
        receiveStatusByte.rxEvent = rxEvent;
        receiveStatusByte.vbusCode = vbusCode;
        receiveStatusByte.lineState = lineState;
    end

    // ------------------------------------------------------------
    // change detection
    // ------------------------------------------------------------
    logic lineChanged;
    logic vbusChanged;
    logic idChanged;

    urc_change_det #(.WIDTH(2)) uLineDet (
        .clk(clk),
        .sys_rst(sys_rst),
        .level(lineState),
        .changed(lineChanged)
    );

    urc_change_det #(.WIDTH(3)) uVbusDet (
        .clk(clk),
        .sys_rst(sys_rst),
        .level({sense.busVoltageAboveValid, sense.sessionValid,
                sense.sessionEndIndicator}),
        .changed(vbusChanged)
    );

    urc_change_det #(.WIDTH(1)) uIdDet (
        .clk(clk),
        .sys_rst(sys_rst),
        .level(sense.idPin),
        .changed(idChanged)
    );

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setupPhase;
    logic accessPhase;
    logic addrHit;
    logic sendEnable;

    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign pready = 1'b1; // zero wait states
    assign addrHit = (paddr == urc_pkg::OFS_EVENT_LATCH)
        || (paddr == urc_pkg::OFS_EVENT_MASK)
        || (paddr == urc_pkg::OFS_STATUS_VIEW)
        || (paddr == urc_pkg::OFS_CONTROL);
    assign pslverr = accessPhase && !addrHit;

    // read data loaded during setup so it stands through the access cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                urc_pkg::OFS_EVENT_LATCH: begin
                    prdata[urc_pkg::EVT_WIDTH-1:0] <= eventLatch | eventSet;
                end
                urc_pkg::OFS_EVENT_MASK: begin
                    prdata[urc_pkg::EVT_WIDTH-1:0] <= eventMask;
                end
                urc_pkg::OFS_STATUS_VIEW: begin
                    prdata[7:0] <= receiveStatusByte;
                end
                urc_pkg::OFS_CONTROL: begin
                    prdata[urc_pkg::CTRL_SEND_ENABLE] <= sendEnable;
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // mask and control writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eventMask <= urc_pkg::RST_EVENT_MASK;
            sendEnable <= urc_pkg::RST_SEND_ENABLE;
        end else if (accessPhase && pwrite) begin
            if (paddr == urc_pkg::OFS_EVENT_MASK) begin
                eventMask <= pwdata[urc_pkg::EVT_WIDTH-1:0];
            end
            if (paddr == urc_pkg::OFS_CONTROL) begin
                sendEnable <= pwdata[urc_pkg::CTRL_SEND_ENABLE];
            end
        end
    end

    // ------------------------------------------------------------
    // event latch and interrupt
    // ------------------------------------------------------------
    always_comb begin
        eventSet = '0;
        eventSet[urc_pkg::EVT_ID_CHANGE] = idChanged; // [R5]
        eventSet[urc_pkg::EVT_ID_MEASURE_DONE] =
            idResistanceMeasureDone; // [R5]
    end

    // a read clears the latch; an event in that same cycle survives
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eventLatch <= '0;
        end else if (accessPhase && !pwrite
                     && paddr == urc_pkg::OFS_EVENT_LATCH) begin
            eventLatch <= eventSet; // [R4]
        end else begin
            eventLatch <= eventLatch | eventSet; // [R5]
        end
    end

    assign irq = altEvent;

    // ------------------------------------------------------------
    // sending the status byte
    // ------------------------------------------------------------
    urc_pkg::urc_send_state_t sendState;
    logic pending;
    logic rxDirQ;
    logic rxSlot;
    logic ownSlot;

    // a receive slot needs one turnaround cycle after direction rises
    assign rxSlot = usbRxDir && rxDirQ && !usbRxNxt; // [R11]
    assign ownSlot = (sendState == urc_pkg::SEND_BYTE);
    assign statusSent = rxSlot || ownSlot;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxDirQ <= 1'b0;
        end else begin
            rxDirQ <= usbRxDir;
        end
    end

    // change requests a byte; a new change while sending keeps it pending
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending <= 1'b0;
        end else if (lineChanged || vbusChanged || idChanged) begin
            pending <= 1'b1; // [R9] [R10]
        end else if (statusSent) begin
            pending <= 1'b0;
        end
    end

    // own transfer: turnaround, one byte, then hand the bus back
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sendState <= urc_pkg::SEND_IDLE;
        end else begin
            unique case (sendState)
                urc_pkg::SEND_IDLE: begin
                    if (pending && sendEnable && !usbRxDir) begin
                        sendState <= urc_pkg::SEND_TURN; // [R9] [R10]
                    end
                end
                urc_pkg::SEND_TURN: begin
                    // receiver took the bus; its slots carry the byte
                    if (usbRxDir) begin
                        sendState <= urc_pkg::SEND_IDLE;
                    end else begin
                        sendState <= urc_pkg::SEND_BYTE;
                    end
                end
                urc_pkg::SEND_BYTE: begin
                    sendState <= urc_pkg::SEND_IDLE;
                end
            endcase
        end
    end

    // byte register always tracks the live fields, one cycle behind
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ulpiData <= 8'h00;
        end else begin
            ulpiData <= receiveStatusByte; // [R11]
        end
    end

    assign ulpiDir = usbRxDir || (sendState != urc_pkg::SEND_IDLE);
    assign ulpiDataOeN = !statusSent;

endmodule // urc_rx_status_top

// *** design/urc_pkg.sv ***
/*
 * Shared constants and types for the receive status byte encoder:
 * register offsets, field positions, reset values and the byte layout.
 * Assumes a single 10 MHz clock domain and an APB master with 32-bit data.
 */
package urc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_EVENT_LATCH = 8'h00;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h04;
    localparam logic [7:0] OFS_STATUS_VIEW = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0C;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int EVT_ID_CHANGE = 0;
    localparam int EVT_ID_MEASURE_DONE = 1;
    localparam int EVT_WIDTH = 2;
    localparam int CTRL_SEND_ENABLE = 0;
    localparam logic [1:0] RST_EVENT_MASK = 2'h0;
    localparam logic RST_SEND_ENABLE = 1'b1;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] RXEV_NONE = 2'h0;
    localparam logic [1:0] RXEV_ACTIVE = 2'h1;
    localparam logic [1:0] RXEV_ACTIVE_ERROR = 2'h3;
    localparam logic [1:0] RXEV_HOST_DISCONNECT = 2'h2;
    localparam logic [1:0] VBUS_BELOW_END = 2'h0;
    localparam logic [1:0] VBUS_END_TO_SESSION = 2'h1;
    localparam logic [1:0] VBUS_SESSION_TO_VALID = 2'h2;
    localparam logic [1:0] VBUS_ABOVE_VALID = 2'h3;

    // receive status byte, msb first
    typedef struct packed {
        logic altEvent;
        logic idLevel;
        logic [1:0] rxEvent;
        logic [1:0] vbusCode;
        logic [1:0] lineState;
    } urc_status_t;

    // comparator and line inputs that drive a fresh status byte
    typedef struct packed {
        logic fsDp;
        logic fsDm;
        logic sessionEndIndicator;
        logic sessionValid;
        logic busVoltageAboveValid;
        logic idPin;
    } urc_sense_t;

    typedef enum {
        SEND_IDLE,
        SEND_TURN,
        SEND_BYTE
    } urc_send_state_t;

endpackage

// *** design/urc_change_det.sv ***
/*
 * Change detector: flags any bit of a level input that differs from
 * its value one clock earlier.
 * Assumes the input is already synchronous to clk.
 */
`timescale 1ns/1ps

module urc_change_det #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] level,
    output logic changed
);

    // ------------------------------------------------------------
    // previous value
    // ------------------------------------------------------------
    logic [WIDTH-1:0] levelQ;
    logic primed;

    // elaboration check: a zero-width level has nothing to compare
    if (WIDTH < 1) begin : gBadWidth
        $error("urc_change_det: WIDTH must be at least 1");
    end

    // primed keeps the first sample after reset from looking like a change
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            levelQ <= '0;
            primed <= 1'b0;
        end else begin
            levelQ <= level;
            primed <= 1'b1;
        end
    end

    assign changed = primed && (level != levelQ);

endmodule // urc_change_det

// *** sim/urc_checker.sv ***
/*
 * Concurrent checks on the receive status byte encoder top ports.
 * Assumes one clock, clk, and the asynchronous reset sys_rst.
 */
`timescale 1ns/1ps

module urc_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic irq,
    input wire urc_pkg::urc_sense_t sense,
    input wire logic rxActive,
    input wire logic rxError,
    input wire logic hostDisconnect,
    input wire logic usbRxDir,
    input wire logic usbRxNxt,
    input wire logic ulpiDir,
    input wire logic [7:0] ulpiData,
    input wire logic ulpiDataOeN,
    input wire logic statusSent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // the bus byte lags the live fields by one cycle
    property p_line;
        !$past(sys_rst) |-> ulpiData[1:0] == $past({sense.fsDm, sense.fsDp});
    endproperty
    a_line: assert property (p_line) else $error("line state wrong");
    property p_id;
        !$past(sys_rst) |-> ulpiData[6] == $past(sense.idPin);
    endproperty
    a_id: assert property (p_id) else $error("id field wrong");
    property p_alt;
        !$past(sys_rst) |-> ulpiData[7] == $past(irq);
    endproperty
    a_alt: assert property (p_alt) else $error("alt flag wrong");
    property p_rxev;
        !$past(sys_rst) |-> ulpiData[5:4] == ($past(hostDisconnect) ? 2'h2 :
            ($past(rxActive) ? {$past(rxError), 1'h1} : 2'h0));
    endproperty
    a_rxev: assert property (p_rxev) else $error("rx event field wrong");
    property p_vbus;
        !$past(sys_rst) |-> ulpiData[3:2] ==
            ($past(sense.busVoltageAboveValid) ? 2'h3 :
            ($past(sense.sessionValid) ? 2'h2 :
            ($past(sense.sessionEndIndicator) ? 2'h0 : 2'h1)));
    endproperty
    a_vbus: assert property (p_vbus) else $error("vbus field wrong");
    // early edges are skipped while the change detectors prime
    property p_line_send;
        $changed({sense.fsDp, sense.fsDm}) && !usbRxDir && !$past(sys_rst, 2)
            |-> ##[1:3] statusSent;
    endproperty
    a_line_send: assert property (p_line_send) else $error("no byte");
    property p_cmp_send;
        $changed(sense[3:0]) && !usbRxDir && !$past(sys_rst, 2)
            |-> ##[1:3] statusSent;
    endproperty
    a_cmp_send: assert property (p_cmp_send) else $error("no byte");
    property p_slot;
        usbRxDir && $past(usbRxDir) && !usbRxNxt
            |-> statusSent && !ulpiDataOeN && ulpiDir;
    endproperty
    a_slot: assert property (p_slot) else $error("missed rx slot");
    c_slot: cover property (statusSent && usbRxDir);
    c_alt: cover property (statusSent && ulpiData[7]);
    c_disc: cover property (ulpiData[5:4] == 2'h2);
endmodule // urc_checker

bind urc_rx_status_top urc_checker chk (.clk(clk), .sys_rst(sys_rst),
    .irq(irq), .sense(sense), .rxActive(rxActive), .rxError(rxError),
    .hostDisconnect(hostDisconnect), .usbRxDir(usbRxDir),
    .usbRxNxt(usbRxNxt), .ulpiDir(ulpiDir), .ulpiData(ulpiData),
    .ulpiDataOeN(ulpiDataOeN), .statusSent(statusSent));

// *** sim/urc_link_model.sv ***
/*
 * Link controller model: captures every status byte it is handed.
 * Assumes bytes are valid on the bus in cycles with statusSent high.
 */
`timescale 1ns/1ps

module urc_link_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] ulpiData,
    input wire logic statusSent,
    input wire logic altDone,
    output logic [7:0] lastByte,
    output logic [15:0] nBytes,
    output logic altSeen
);
    // a set alt flag asks for a latch read; held until the read is done
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lastByte <= 8'h00;
            nBytes <= 16'h0000;
            altSeen <= 1'h0;
        end else if (statusSent) begin
            lastByte <= ulpiData;
            nBytes <= nBytes + 16'h0001;
            altSeen <= altSeen | ulpiData[7];
        end else if (altDone) begin
            altSeen <= 1'h0;
        end
    end
endmodule // urc_link_model

// *** sim/urc_rx_status_top_tb.sv ***
/*
 * Self-checking bench for the receive status byte encoder.
 * Assumes zero-wait APB and the link model on the status bus.
 */
`timescale 1ns/1ps

module urc_rx_status_top_tb;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, altDone = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, irq, ulpiDir, ulpiDataOeN, statusSent;
    urc_pkg::urc_sense_t sense = 6'h08;
    logic rxActive = 1'h0, rxError = 1'h0, hostDisconnect = 1'h0;
    logic idDone = 1'h0, usbRxDir = 1'h0, usbRxNxt = 1'h0, altSeen;
    logic [7:0] ulpiData, lastByte;
    logic [15:0] nBytes;
    int n_errors = 0, n_compared = 0;

    always #50 clk = ~clk;

    urc_rx_status_top uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .sense(sense), .rxActive(rxActive), .rxError(rxError),
        .hostDisconnect(hostDisconnect), .idResistanceMeasureDone(idDone),
        .usbRxDir(usbRxDir), .usbRxNxt(usbRxNxt), .ulpiDir(ulpiDir),
        .ulpiData(ulpiData), .ulpiDataOeN(ulpiDataOeN),
        .statusSent(statusSent));
    urc_link_model link (.clk(clk), .sys_rst(sys_rst), .ulpiData(ulpiData),
        .statusSent(statusSent), .altDone(altDone), .lastByte(lastByte),
        .nBytes(nBytes), .altSeen(altSeen));

    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'h1) break;
        end
        if (k == 20) chk("pready", 1, 0);
        if (k == 20) complete_run;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wait_sent;
        int k;
        for (k = 0; k < 10; k++) begin
            @(negedge clk);
            if (statusSent === 1'h1) break;
        end
        if (k == 10) chk("statusSent", 1, 0);
        if (k == 10) complete_run;
    endtask

    // expected byte from the bench's own view of the inputs
    function automatic logic [7:0] expb(input logic alt);
        logic [1:0] r;
        logic [1:0] v;
        r = hostDisconnect ? 2'h2 : (rxActive ? {rxError, 1'h1} : 2'h0);
        v = sense.busVoltageAboveValid ? 2'h3 : (sense.sessionValid ? 2'h2 :
            (sense.sessionEndIndicator ? 2'h0 : 2'h1));
        return {alt, sense.idPin, r, v, sense.fsDm, sense.fsDp};
    endfunction

    task automatic t_regs;
        apb(1'h0, urc_pkg::OFS_EVENT_MASK, 0);
        chk("mask", 32'(urc_pkg::RST_EVENT_MASK), rd);
        apb(1'h0, urc_pkg::OFS_CONTROL, 0);
        chk("control", 32'(urc_pkg::RST_SEND_ENABLE), rd);
        apb(1'h1, urc_pkg::OFS_CONTROL, 32'h0);
        apb(1'h0, urc_pkg::OFS_CONTROL, 0);
        chk("control off", 0, rd);
        apb(1'h1, urc_pkg::OFS_CONTROL, 32'h1);
        apb(1'h0, urc_pkg::OFS_CONTROL, 0);
        chk("control on", 1, rd);
        apb(1'h0, 8'h10, 0);
        chk("unmapped error", 1, err);
        $display("t_regs done");
    endtask

    // every rx event, vbus code and line state, incl. SE0 and SE1
    task automatic t_fields;
        logic [2:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            @(posedge clk);
            {hostDisconnect, rxActive, rxError} <= v;
            sense <= {v[0], v[1], v, v[2]};
            apb(1'h0, urc_pkg::OFS_STATUS_VIEW, 0);
            chk("status view", expb(1'h0), rd);
        end
        @(posedge clk);
        {hostDisconnect, rxActive, rxError} <= 3'h0;
        sense <= 6'h08;
        repeat (6) @(posedge clk);
        $display("t_fields done");
    endtask

    // line, session comparator and id changes each send a byte
    task automatic t_send;
        logic [5:0] flip [3] = '{6'h20, 6'h04, 6'h01};
        logic [15:0] n0;
        for (int j = 0; j < 3; j++) begin
            @(posedge clk);
            n0 = nBytes;
            sense <= sense ^ flip[j];
            wait_sent;
            chk("sent byte", expb(irq), ulpiData);
            chk("own dir", 1, ulpiDir);
            @(negedge clk);
            chk("link byte", expb(irq), lastByte);
            chk("link count", 32'(n0) + 1, nBytes);
            repeat (6) @(posedge clk);
        end
        $display("t_send done");
    endtask

    task automatic pulse_done;
        @(posedge clk);
        idDone <= 1'h1;
        @(posedge clk);
        idDone <= 1'h0;
        @(negedge clk);
    endtask

    task automatic t_event;
        apb(1'h0, urc_pkg::OFS_EVENT_LATCH, 0);
        apb(1'h1, urc_pkg::OFS_EVENT_MASK, 32'h3);
        apb(1'h0, urc_pkg::OFS_EVENT_MASK, 0);
        chk("mask", 32'h3, rd);
        pulse_done;
        chk("irq", 1, irq);
        @(posedge clk);
        sense <= sense ^ 6'h20;
        wait_sent;
        chk("alt flag", 1, ulpiData[7]);
        @(negedge clk);
        chk("link alt", 1, altSeen);
        apb(1'h0, urc_pkg::OFS_EVENT_LATCH, 0);
        chk("latch", 32'h2, rd);
        altDone <= 1'h1;
        @(negedge clk);
        chk("irq clear", 0, irq);
        @(posedge clk);
        altDone <= 1'h0;
        @(negedge clk);
        chk("link alt clear", 0, altSeen);
        @(posedge clk);
        sense <= sense ^ 6'h01;
        wait_sent;
        @(negedge clk);
        chk("id irq", 1, irq);
        apb(1'h0, urc_pkg::OFS_EVENT_LATCH, 0);
        chk("id latch", 32'h1, rd);
        apb(1'h1, urc_pkg::OFS_EVENT_MASK, 0);
        pulse_done;
        chk("masked irq", 0, irq);
        apb(1'h0, urc_pkg::OFS_STATUS_VIEW, 0);
        chk("masked alt", 0, rd[7]);
        apb(1'h0, urc_pkg::OFS_EVENT_LATCH, 0);
        chk("masked latch", 32'h2, rd);
        $display("t_event done");
    endtask

    // receive: turnaround, then a byte in each cycle with next low
    task automatic t_slot;
        @(posedge clk);
        usbRxDir <= 1'h1;
        @(negedge clk);
        chk("turnaround", 0, statusSent);
        @(negedge clk);
        chk("slot sent", 1, statusSent);
        chk("slot oe", 0, ulpiDataOeN);
        chk("slot byte", expb(irq), ulpiData);
        @(posedge clk);
        usbRxNxt <= 1'h1;
        @(negedge clk);
        chk("data cycle", 0, statusSent);
        @(posedge clk);
        usbRxNxt <= 1'h0;
        usbRxDir <= 1'h0;
        repeat (4) @(posedge clk);
        $display("t_slot done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (2) @(posedge clk);
        t_regs;
        t_fields;
        t_send;
        t_event;
        t_slot;
        complete_run;
    end
endmodule // urc_rx_status_top_tb
